// file: hdl/fdc_pkg.sv
package fdc_pkg;

  // ==========================================
  // Register offsets
  localparam logic [7:0] FDC_A_RATE12 = 8'h25;
  localparam logic [7:0] FDC_A_RATE34 = 8'h26;
  localparam logic [7:0] FDC_A_MIN1 = 8'h28;
  localparam logic [7:0] FDC_A_MIN2 = 8'h29;
  localparam logic [7:0] FDC_A_MIN3 = 8'h2a;
  localparam logic [7:0] FDC_A_MIN4 = 8'h2b;
  localparam logic [7:0] FDC_A_MAX = 8'h2c;
  localparam logic [7:0] FDC_A_TMASK = 8'h30;
  localparam logic [7:0] FDC_A_PMASK = 8'h31;
  localparam logic [7:0] FDC_A_VMASK = 8'h32;

  // ==========================================
  // Reset values
  localparam logic [7:0] FDC_RST_RATE = 8'h90;
  localparam logic [7:0] FDC_RST_MIN = 8'h80;
  localparam logic [7:0] FDC_RST_MAX = 8'hc0;
  localparam logic [7:0] FDC_RST_TMASK = 8'h00;
  localparam logic [7:0] FDC_RST_PMASK = 8'hc0;
  localparam logic [7:0] FDC_RST_VMASK = 8'h00;
  localparam logic [7:0] FDC_RD_NONE = 8'h00;

  // ==========================================
  // Field layout of the rate registers
  localparam int FDC_FLOOR_A = 0;
  localparam int FDC_FLOOR_B = 1;
  localparam int FDC_RATE_A = 2;
  localparam int FDC_RATE_B = 5;
  localparam int FDC_RATE_W = 3;

  // ==========================================
  // Control source codes
  localparam logic [2:0] FDC_SRC_OFF = 3'h4;
  localparam logic [2:0] FDC_SRC_MANUAL = 3'h7;
  localparam logic [7:0] FDC_DUTY_ZERO = 8'h00;

  // ==========================================
  // Low-frequency rates in tenths of a hertz
  localparam int unsigned FDC_CLK_HZ = 125000000;
  localparam int unsigned FDC_CLK_DHZ = FDC_CLK_HZ * 10;
  localparam int FDC_PER_W = 24;
  localparam int unsigned FDC_RATE_DHZ [8] = '{110, 147, 221, 294,
                                              353, 441, 588, 882};

  typedef struct packed {
    logic [7:0] rate12;
    logic [7:0] rate34;
    logic [3:0][7:0] min_duty;
    logic [7:0] max_duty;
    logic [7:0] tmask;
    logic [7:0] pmask;
    logic [7:0] vmask;
  } fdc_regs_s;

  localparam fdc_regs_s FDC_REGS_RST = '{
    rate12: FDC_RST_RATE, rate34: FDC_RST_RATE,
    min_duty: {4{FDC_RST_MIN}}, max_duty: FDC_RST_MAX,
    tmask: FDC_RST_TMASK, pmask: FDC_RST_PMASK, vmask: FDC_RST_VMASK};

  typedef struct packed {
    logic [2:0] src_sel;
    logic below_thresh;
    logic [7:0] loop_duty;
    logic [7:0] manual_duty;
  } fdc_chan_in_s;

  typedef struct packed {
    logic [7:0] duty;
    logic [FDC_PER_W-1:0] period;
    logic [2:0] rate;
  } fdc_chan_out_s;

  typedef struct packed {
    logic [7:0] volt;
    logic [7:0] pin;
    logic [7:0] temp;
  } fdc_events_s;

  typedef struct packed {
    fdc_regs_s regs;
    logic lock;
    logic [7:0] rdata;
    logic refused;
    logic alert;
  } fdc_bank_st_s;

endpackage : fdc_pkg

// file: hdl/fdc_mask_gate.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_mask_gate #(
  parameter int W = 8
) (
  input wire logic [W-1:0] status_in,
  input wire logic [W-1:0] mask_in,
  output logic [W-1:0] pass_out,
  output logic any_out
);
  // ==========================================
  // Gate
  // Status itself is never touched here
  assign pass_out = status_in & ~mask_in;
  assign any_out = |pass_out;
endmodule : fdc_mask_gate
`default_nettype wire

// file: hdl/fdc_drive.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_drive (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire fdc_pkg::fdc_chan_in_s chan_in,
  input wire logic floor_en_in,
  input wire logic [2:0] rate_in,
  input wire logic [7:0] min_duty_in,
  input wire logic [7:0] max_duty_in,
  output var fdc_pkg::fdc_chan_out_s chan_out
);
  fdc_pkg::fdc_chan_out_s st_ff;
  fdc_pkg::fdc_chan_out_s nxt_st;
  logic auto_mode;
  logic [7:0] lifted;

  // ==========================================
  // Duty selection
  always_comb begin
    auto_mode = (chan_in.src_sel != fdc_pkg::FDC_SRC_OFF) &&
                (chan_in.src_sel != fdc_pkg::FDC_SRC_MANUAL);
    lifted = (chan_in.loop_duty < min_duty_in) ? min_duty_in : chan_in.loop_duty;
    nxt_st = st_ff;
    nxt_st.rate = rate_in;
    nxt_st.period = fdc_pkg::FDC_PER_W'(fdc_pkg::FDC_CLK_DHZ /
                                        fdc_pkg::FDC_RATE_DHZ[rate_in]);
    if (chan_in.src_sel == fdc_pkg::FDC_SRC_OFF) begin
      nxt_st.duty = fdc_pkg::FDC_DUTY_ZERO;
    end else if (!auto_mode) begin
      nxt_st.duty = chan_in.manual_duty;
    end else if (chan_in.below_thresh) begin
      nxt_st.duty = floor_en_in ? min_duty_in : fdc_pkg::FDC_DUTY_ZERO;
    end else begin
      // Cap wins if software sets minimum above maximum
      nxt_st.duty = (lifted > max_duty_in) ? max_duty_in : lifted;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign chan_out = st_ff;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_floor_zero: assert property (auto_mode && chan_in.below_thresh && !floor_en_in
    |=> chan_out.duty == fdc_pkg::FDC_DUTY_ZERO)
    else $error("floor off but duty not zero");
  a_floor_min: assert property (auto_mode && chan_in.below_thresh && floor_en_in
    |=> chan_out.duty == $past(min_duty_in))
    else $error("floor on but duty not minimum");
  a_duty_cap: assert property (auto_mode && !chan_in.below_thresh
    |=> chan_out.duty <= $past(max_duty_in))
    else $error("automatic duty above cap");
  a_off_zero: assert property (chan_in.src_sel == fdc_pkg::FDC_SRC_OFF
    |=> chan_out.duty == fdc_pkg::FDC_DUTY_ZERO)
    else $error("off source but duty not zero");
endmodule : fdc_drive
`default_nettype wire

// file: hdl/fdc_bank.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_bank (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_refused_out,
  input wire logic lock_in,
  input wire logic sw_reset_in,
  input wire fdc_pkg::fdc_chan_in_s [3:0] chan_in,
  input wire fdc_pkg::fdc_events_s events_in,
  output var fdc_pkg::fdc_chan_out_s [3:0] chan_out,
  output logic lock_out,
  output logic alert_out
);
  fdc_pkg::fdc_bank_st_s st_ff;
  fdc_pkg::fdc_bank_st_s nxt_st;
  logic lockable;
  logic mapped;
  logic [7:0] rd_val;
  logic [3:0] floor_en;
  logic [3:0][2:0] rate_code;
  logic temp_any;
  logic pin_any;
  logic volt_any;

  // ==========================================
  // Address decode
  always_comb begin
    lockable = 1'b0;
    mapped = 1'b1;
    rd_val = fdc_pkg::FDC_RD_NONE;
    unique case (reg_addr_in)
      fdc_pkg::FDC_A_RATE12: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.rate12;
      end
      fdc_pkg::FDC_A_RATE34: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.rate34;
      end
      fdc_pkg::FDC_A_MIN1: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.min_duty[0];
      end
      fdc_pkg::FDC_A_MIN2: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.min_duty[1];
      end
      fdc_pkg::FDC_A_MIN3: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.min_duty[2];
      end
      fdc_pkg::FDC_A_MIN4: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.min_duty[3];
      end
      fdc_pkg::FDC_A_MAX: begin
        lockable = 1'b1;
        rd_val = st_ff.regs.max_duty;
      end
      fdc_pkg::FDC_A_TMASK: begin
        rd_val = st_ff.regs.tmask;
      end
      fdc_pkg::FDC_A_PMASK: begin
        rd_val = st_ff.regs.pmask;
      end
      fdc_pkg::FDC_A_VMASK: begin
        rd_val = st_ff.regs.vmask;
      end
      default: begin
        // Unmapped: reads zero, writes dropped
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Register writes and state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.refused = 1'b0;
    // Lock is sticky; only power-on clears it
    nxt_st.lock = st_ff.lock | lock_in;
    if (reg_rd_in) begin
      nxt_st.rdata = rd_val;
    end
    if (reg_wr_in && mapped && lockable && st_ff.lock) begin
      nxt_st.refused = 1'b1;
    end else if (reg_wr_in && mapped) begin
      unique case (reg_addr_in)
        fdc_pkg::FDC_A_RATE12: begin
          nxt_st.regs.rate12 = reg_wdata_in;
        end
        fdc_pkg::FDC_A_RATE34: begin
          nxt_st.regs.rate34 = reg_wdata_in;
        end
        fdc_pkg::FDC_A_MIN1: begin
          nxt_st.regs.min_duty[0] = reg_wdata_in;
        end
        fdc_pkg::FDC_A_MIN2: begin
          nxt_st.regs.min_duty[1] = reg_wdata_in;
        end
        fdc_pkg::FDC_A_MIN3: begin
          nxt_st.regs.min_duty[2] = reg_wdata_in;
        end
        fdc_pkg::FDC_A_MIN4: begin
          nxt_st.regs.min_duty[3] = reg_wdata_in;
        end
        fdc_pkg::FDC_A_MAX: begin
          nxt_st.regs.max_duty = reg_wdata_in;
        end
        fdc_pkg::FDC_A_TMASK: begin
          // Reserved bit 0 kept as a plain bit
          nxt_st.regs.tmask = reg_wdata_in;
        end
        fdc_pkg::FDC_A_PMASK: begin
          nxt_st.regs.pmask = reg_wdata_in;
        end
        fdc_pkg::FDC_A_VMASK: begin
          nxt_st.regs.vmask = reg_wdata_in;
        end
        default: begin
          nxt_st.regs = st_ff.regs;
        end
      endcase
    end
    // Software reset beats a write in the same cycle
    if (sw_reset_in) begin
      nxt_st.regs = fdc_pkg::FDC_REGS_RST;
    end
    // Alert follows the live masks; events pass untouched
    nxt_st.alert = temp_any | pin_any | volt_any;
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_ff.regs <= fdc_pkg::FDC_REGS_RST;
      st_ff.lock <= 1'b0;
      st_ff.rdata <= fdc_pkg::FDC_RD_NONE;
      st_ff.refused <= 1'b0;
      st_ff.alert <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================
  // Alert masking
  fdc_mask_gate #(.W(8)) u_temp_gate (
    .status_in(events_in.temp),
    .mask_in(st_ff.regs.tmask),
    .pass_out(),
    .any_out(temp_any)
  );

  fdc_mask_gate #(.W(8)) u_pin_gate (
    .status_in(events_in.pin),
    .mask_in(st_ff.regs.pmask),
    .pass_out(),
    .any_out(pin_any)
  );

  fdc_mask_gate #(.W(8)) u_volt_gate (
    .status_in(events_in.volt),
    .mask_in(st_ff.regs.vmask),
    .pass_out(),
    .any_out(volt_any)
  );

  // ==========================================
  // Fan drive channels
  always_comb begin
    floor_en[0] = st_ff.regs.rate12[fdc_pkg::FDC_FLOOR_A];
    floor_en[1] = st_ff.regs.rate12[fdc_pkg::FDC_FLOOR_B];
    floor_en[2] = st_ff.regs.rate34[fdc_pkg::FDC_FLOOR_A];
    floor_en[3] = st_ff.regs.rate34[fdc_pkg::FDC_FLOOR_B];
    rate_code[0] = st_ff.regs.rate12[fdc_pkg::FDC_RATE_A +: fdc_pkg::FDC_RATE_W];
    rate_code[1] = st_ff.regs.rate12[fdc_pkg::FDC_RATE_B +: fdc_pkg::FDC_RATE_W];
    rate_code[2] = st_ff.regs.rate34[fdc_pkg::FDC_RATE_A +: fdc_pkg::FDC_RATE_W];
    rate_code[3] = st_ff.regs.rate34[fdc_pkg::FDC_RATE_B +: fdc_pkg::FDC_RATE_W];
  end

  for (genvar i = 0; i < 4; i++) begin : g_drive
    fdc_drive u_drive (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .chan_in(chan_in[i]),
      .floor_en_in(floor_en[i]),
      .rate_in(rate_code[i]),
      .min_duty_in(st_ff.regs.min_duty[i]),
      .max_duty_in(st_ff.regs.max_duty),
      .chan_out(chan_out[i])
    );
  end

  // ==========================================
  // Outputs
  assign reg_rdata_out = st_ff.rdata;
  assign reg_refused_out = st_ff.refused;
  assign lock_out = st_ff.lock;
  assign alert_out = st_ff.alert;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_rate_swrst: assert property (sw_reset_in
    |=> st_ff.regs.rate12 == fdc_pkg::FDC_RST_RATE
        && st_ff.regs.rate34 == fdc_pkg::FDC_RST_RATE)
    else $error("rate registers not restored");

  a_min_swrst: assert property (sw_reset_in
    |=> st_ff.regs.min_duty == {4{fdc_pkg::FDC_RST_MIN}})
    else $error("minimum duty not restored");

  a_max_swrst: assert property (sw_reset_in
    |=> st_ff.regs.max_duty == fdc_pkg::FDC_RST_MAX)
    else $error("maximum duty not restored");

  a_lock_holds: assert property (st_ff.lock && reg_wr_in && lockable && !sw_reset_in
    |=> $stable(st_ff.regs) && reg_refused_out)
    else $error("locked register changed");

  a_lock_sticky: assert property (lock_in |=> lock_out [*8])
    else $error("lock dropped before power-on");

  a_tmask_write: assert property (st_ff.lock && reg_wr_in && !sw_reset_in
    && reg_addr_in == fdc_pkg::FDC_A_TMASK
    |=> st_ff.regs.tmask == $past(reg_wdata_in) && !reg_refused_out)
    else $error("temperature mask write lost");

  a_pmask_swrst: assert property (sw_reset_in
    |=> st_ff.regs.pmask == fdc_pkg::FDC_RST_PMASK
        && st_ff.regs.tmask == fdc_pkg::FDC_RST_TMASK
        && st_ff.regs.vmask == fdc_pkg::FDC_RST_VMASK)
    else $error("mask registers not restored");

  a_vmask_write: assert property (reg_wr_in && !sw_reset_in
    && reg_addr_in == fdc_pkg::FDC_A_VMASK
    |=> st_ff.regs.vmask == $past(reg_wdata_in))
    else $error("voltage mask write lost");

  a_alert_gate: assert property (alert_out == $past(
    |(events_in.temp & ~st_ff.regs.tmask)
    || |(events_in.pin & ~st_ff.regs.pmask)
    || |(events_in.volt & ~st_ff.regs.vmask)))
    else $error("alert disagrees with masked events");

  a_read_data: assert property (reg_rd_in && !reg_wr_in
    && reg_addr_in == fdc_pkg::FDC_A_MAX
    |=> reg_rdata_out == $past(st_ff.regs.max_duty))
    else $error("read data wrong");

  // Pin masks stay writable after lock so alerts can still be tuned
  a_pmask_write: assert property (st_ff.lock && reg_wr_in && !sw_reset_in
    && reg_addr_in == fdc_pkg::FDC_A_PMASK
    |=> st_ff.regs.pmask == $past(reg_wdata_in) && !reg_refused_out)
    else $error("thermal pin mask write lost");

  a_unlocked_write: assert property (!st_ff.lock && reg_wr_in
    |=> !reg_refused_out)
    else $error("write refused while unlocked");

  c_locked_write: cover property (st_ff.lock && reg_wr_in && lockable);
  c_masked_event: cover property (|events_in.temp && !temp_any);
  c_alert_rise: cover property (!alert_out ##1 alert_out);
  c_sw_reset: cover property (sw_reset_in && reg_wr_in);
endmodule : fdc_bank
`default_nettype wire

// file: test/fdc_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Register host model, drives the byte port
module fdc_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out,
  output logic rd_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
    rd_out = 1'b0;
  end

  // Released lines show the inverse, not a stale value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : write

  // Read data is one cycle late, taken at the next falling edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : read
endmodule : fdc_host
`default_nettype wire

// file: test/fdc_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module fdc_bank_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic lock_in = 1'b0;
  logic sw_reset_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_refused, lock_out, alert_out;
  fdc_pkg::fdc_chan_in_s [3:0] chan_in = '0;
  fdc_pkg::fdc_events_s events_in = '0;
  fdc_pkg::fdc_chan_out_s [3:0] chan_out;
  int n_errors = 0;
  int total_checks = 0;
  int unsigned dhz [8] = '{110, 147, 221, 294, 353, 441, 588, 882};

  always #4 clk_in = ~clk_in;

  fdc_host host (.clk_in(clk_in), .rdata_in(reg_rdata), .addr_out(reg_addr),
    .wr_out(reg_wr), .wdata_out(reg_wdata), .rd_out(reg_rd));

  fdc_bank DUT (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .reg_refused_out(reg_refused), .lock_in(lock_in),
    .sw_reset_in(sw_reset_in), .chan_in(chan_in), .events_in(events_in),
    .chan_out(chan_out), .lock_out(lock_out), .alert_out(alert_out));

  // ==========================================
  // Shared helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read(a, d);
    chk($sformatf("register %h", a), {24'h0, exp}, {24'h0, d});
  endtask : rd_chk

  task automatic set_ch(input int i, input logic [2:0] s, input logic b,
                        input logic [7:0] l, input logic [7:0] m);
    chan_in[i] = '{src_sel: s, below_thresh: b, loop_duty: l, manual_duty: m};
  endtask : set_ch

  task automatic duty_chk(input logic [7:0] e0, e1, e2, e3);
    @(negedge clk_in);
    chk("duty 1", {24'h0, e0}, {24'h0, chan_out[0].duty});
    chk("duty 2", {24'h0, e1}, {24'h0, chan_out[1].duty});
    chk("duty 3", {24'h0, e2}, {24'h0, chan_out[2].duty});
    chk("duty 4", {24'h0, e3}, {24'h0, chan_out[3].duty});
  endtask : duty_chk

  // ==========================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] a [11] = '{8'h25, 8'h26, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c,
                           8'h30, 8'h31, 8'h32, 8'h27};
    logic [7:0] e [11] = '{8'h90, 8'h90, 8'h80, 8'h80, 8'h80, 8'h80, 8'hc0,
                           8'h00, 8'hc0, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rd_chk(a[i], e[i]);
    end
    $display("test reset values done");
  endtask : t_reset

  task automatic t_drive();
    logic [2:0] c, k;
    for (int i = 0; i < 4; i++) begin
      set_ch(i, 3'h0, 1'b1, 8'h20, 8'h33);
      host.write(8'h28 + 8'(i), 8'h11 * 8'(i + 1));
    end
    duty_chk(8'h00, 8'h00, 8'h00, 8'h00);
    host.write(8'h25, 8'h91);
    host.write(8'h26, 8'h92);
    duty_chk(8'h11, 8'h00, 8'h00, 8'h44);
    set_ch(0, 3'h7, 1'b1, 8'h20, 8'h5e);
    set_ch(1, 3'h4, 1'b0, 8'h90, 8'h5e);
    set_ch(2, 3'h1, 1'b0, 8'hf0, 8'h00);
    set_ch(3, 3'h6, 1'b0, 8'h10, 8'h00);
    duty_chk(8'h5e, 8'h00, 8'hc0, 8'h44);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      k = 3'(7 - i);
      host.write(8'h25, {k, c, 2'b00});
      host.write(8'h26, {c, k, 2'b00});
      @(negedge clk_in);
      chk("rate 1", 32'(c), 32'(chan_out[0].rate));
      chk("rate 2", 32'(k), 32'(chan_out[1].rate));
      chk("rate 3", 32'(k), 32'(chan_out[2].rate));
      chk("rate 4", 32'(c), 32'(chan_out[3].rate));
      chk("period 1", 1250000000 / dhz[i], 32'(chan_out[0].period));
      chk("period 2", 1250000000 / dhz[7 - i], 32'(chan_out[1].period));
      chk("period 3", 1250000000 / dhz[7 - i], 32'(chan_out[2].period));
      chk("period 4", 1250000000 / dhz[i], 32'(chan_out[3].period));
    end
    $display("test drive done");
  endtask : t_drive

  task automatic t_alert();
    logic [7:0] ma;
    host.write(8'h31, 8'h00);
    for (int i = 0; i < 24; i++) begin
      ma = 8'h30 + 8'(i / 8);
      @(negedge clk_in);
      events_in = 24'(1) << i;
      @(negedge clk_in);
      chk($sformatf("alert open %0d", i), 32'h1, 32'(alert_out));
      host.write(ma, 8'(1) << (i % 8));
      @(negedge clk_in);
      chk($sformatf("alert masked %0d", i), 32'h0, 32'(alert_out));
      rd_chk(ma, 8'(1) << (i % 8));
      host.write(ma, 8'h00);
    end
    events_in = '0;
    $display("test alert masks done");
  endtask : t_alert

  task automatic t_lock();
    int n;
    host.write(8'h28, 8'h5a);
    @(negedge clk_in);
    lock_in = 1'b1;
    @(negedge clk_in);
    lock_in = 1'b0;
    chk("lock", 32'h1, 32'(lock_out));
    host.write(8'h28, 8'ha5);
    n = 32'(reg_refused);
    repeat (2) begin
      @(negedge clk_in);
      n += 32'(reg_refused);
    end
    chk("refused pulses", 32'h1, 32'(n));
    rd_chk(8'h28, 8'h5a);
    host.write(8'h30, 8'h0f);
    rd_chk(8'h30, 8'h0f);
    // Software reset lands in the same cycle as a mask write and must win
    fork
      host.write(8'h31, 8'h07);
      begin
        @(negedge clk_in);
        sw_reset_in = 1'b1;
        @(negedge clk_in);
        sw_reset_in = 1'b0;
      end
    join
    rd_chk(8'h28, 8'h80);
    rd_chk(8'h25, 8'h90);
    rd_chk(8'h26, 8'h90);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h31, 8'hc0);
    chk("lock kept", 32'h1, 32'(lock_out));
    $display("test lock and software reset done");
  endtask : t_lock

  task automatic t_power_on();
    host.write(8'h32, 8'h5a);
    rd_chk(8'h32, 8'h5a);
    @(negedge clk_in);
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    chk("lock after power-on", 32'h0, 32'(lock_out));
    rd_chk(8'h32, 8'h00);
    host.write(8'h28, 8'h3c);
    rd_chk(8'h28, 8'h3c);
    $display("test power-on reset done");
  endtask : t_power_on

  // ==========================================
  // Verdict
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Generous against the roughly 340 cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    results();
  end

  initial begin
    repeat (6) @(negedge clk_in);
    resetn_in = 1'b1;
    t_reset();
    t_drive();
    t_alert();
    t_lock();
    t_power_on();
    results();
  end
endmodule : fdc_bank_test
`default_nettype wire
